// file: core/ldmc_pkg.sv
// Shared constants and types for the LED driver mode controller
`default_nettype none
package ldmc_pkg;
    // Comparator thresholds and standalone frequency, kept for reference by the analog front end
    localparam int SHORT_THRESH_MV = 2450;
    localparam int BOOT_UV_THRESH_MV = 2950;
    localparam int SUPPLY_OK_THRESH_MV = 4100;
    localparam int LIMP_LOW_THRESH_MV = 148;
    localparam int STANDALONE_FREQ_KHZ = 437;
    // Timing at the 250 MHz system clock
    localparam int CLK_PERIOD_PS = 4000;
    localparam int FAULT_TIME_US = 3600;
    localparam int FAULT_CYCLES = (FAULT_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int FAULT_TIMER_WIDTH = 24;
    localparam int WDOG_WIDTH = 25;
    localparam logic [4:0] WDOG_TAP_DEFAULT = 5'h18;
    localparam logic [1:0] WDOG_LIMP_COUNT = 2'h3;
    localparam int NUM_CH = 2;
    localparam logic [NUM_CH-1:0] CHAN_OFF = 2'h0;
    // Command codes
    localparam logic [7:0] RESET_TO_LOAD = 8'hC3;
    localparam logic [7:0] RESET_TO_DETECT = 8'hD4;
    localparam logic [1:0] SLEEP_ENTER = 2'h1;
    localparam logic [1:0] SLEEP_WAKE = 2'h0;
    // Defaults
    localparam logic WDOG_EN_DEFAULT = 1'b1;
    localparam logic LIMP_SW_DEFAULT = 1'b0;
    localparam logic PWR_CYCLED_DEFAULT = 1'b1;
    typedef enum logic [6:0] {
        ST_POR = 7'h01,
        ST_DETECT = 7'h02,
        ST_STANDALONE = 7'h04,
        ST_LOAD = 7'h08,
        ST_RUN = 7'h10,
        ST_SLEEP = 7'h20,
        ST_LIMP = 7'h40
    } ldmc_mode_type;
endpackage : ldmc_pkg
`default_nettype wire

// file: core/ldmc_sync.sv
// Two-stage synchroniser for asynchronous comparator and pin levels
`default_nettype none
module ldmc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : ldmc_sync
`default_nettype wire

// file: core/ldmc_wdog.sv
// Communication watchdog: 25-bit counter with programmable tap
`default_nettype none
module ldmc_wdog #(
    parameter int WIDTH = ldmc_pkg::WDOG_WIDTH
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [4:0] tap_i,
    output logic timeout_o
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic timeout_nxt;
    always_comb begin
        timeout_nxt = 1'b0;
        count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
        if (!run_i || restart_i) begin
            count_nxt = '0;
        end else if (count_r[tap_i]) begin
            // Restart after each expiry so timeouts can be counted
            timeout_nxt = 1'b1;
            count_nxt = '0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count_r <= '0;
            timeout_o <= 1'b0;
        end else begin
            count_r <= count_nxt;
            timeout_o <= timeout_nxt;
        end
    end
endmodule : ldmc_wdog
`default_nettype wire

// file: core/ldmc_core.sv
// LED driver operating-mode state machine and output fault flags
`default_nettype none
module ldmc_core #(
    parameter int FAULT_CYCLES = ldmc_pkg::FAULT_CYCLES,
    parameter int TIMER_WIDTH = ldmc_pkg::FAULT_TIMER_WIDTH
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic analog_supply_ok_i,
    input wire logic digital_supply_ok_i,
    input wire logic limp_home_current_low_i,
    input wire logic [ldmc_pkg::NUM_CH-1:0] dimming_input_i,
    input wire logic [ldmc_pkg::NUM_CH-1:0] short_detect_i,
    input wire logic [ldmc_pkg::NUM_CH-1:0] bootstrap_uv_i,
    input wire logic [ldmc_pkg::NUM_CH-1:0] high_side_limit_i,
    input wire logic [ldmc_pkg::NUM_CH-1:0] low_side_limit_i,
    input wire logic [ldmc_pkg::NUM_CH-1:0] error_amp_ov_i,
    input wire logic [ldmc_pkg::NUM_CH-1:0] min_off_time_i,
    input wire logic frame_valid_i,
    input wire logic sys_cfg_a_write_i,
    input wire logic [ldmc_pkg::NUM_CH-1:0] cfg_channel_enable_i,
    input wire logic cfg_limp_home_switch_i,
    input wire logic cfg_watchdog_enable_i,
    input wire logic [ldmc_pkg::NUM_CH-1:0] latch_cfg_i,
    input wire logic [1:0] fault_timer_sel_i,
    input wire logic [4:0] watchdog_tap_i,
    input wire logic reset_write_i,
    input wire logic [7:0] reset_code_i,
    input wire logic sleep_write_i,
    input wire logic [1:0] sleep_code_i,
    input wire logic status_a_read_done_i,
    input wire logic status_b_read_done_i,
    input wire logic status_c_read_done_i,
    output logic [6:0] mode_o,
    output logic [ldmc_pkg::NUM_CH-1:0] channel_enable_bit_o,
    output logic limp_home_switch_bit_o,
    output logic comm_watchdog_enable_bit_o,
    output logic [ldmc_pkg::NUM_CH-1:0] switch_enable_o,
    output logic [ldmc_pkg::NUM_CH-1:0] low_side_on_o,
    output logic [ldmc_pkg::NUM_CH-1:0] comp_discharge_o,
    output logic standalone_defaults_o,
    output logic [ldmc_pkg::NUM_CH-1:0] chan_short_flag_o,
    output logic [ldmc_pkg::NUM_CH-1:0] high_side_limit_flag_o,
    output logic [ldmc_pkg::NUM_CH-1:0] low_side_limit_flag_o,
    output logic [ldmc_pkg::NUM_CH-1:0] error_amp_overvoltage_flag_o,
    output logic [ldmc_pkg::NUM_CH-1:0] bootstrap_undervoltage_flag_o,
    output logic [ldmc_pkg::NUM_CH-1:0] min_off_time_flag_o,
    output logic power_cycled_flag_o,
    output logic comm_watchdog_timeout_flag_o
);
    localparam int CH = ldmc_pkg::NUM_CH;

    logic supply_a_s, supply_d_s, lhi_low_s;
    logic [CH-1:0] dim_s, short_s, bst_s, hs_s, ls_s, eaov_s, minoff_s;
    logic supplies_ok, wd_timeout, wd_run;
    ldmc_pkg::ldmc_mode_type state_r, state_nxt;
    logic [CH-1:0] chan_en_r, chan_en_nxt;
    logic limp_sw_r, limp_sw_nxt, wd_en_r, wd_en_nxt;
    logic [1:0] wd_cnt_r, wd_cnt_nxt;
    logic [CH-1:0] short_nxt, hs_f_nxt, ls_f_nxt, eaov_nxt, bst_f_nxt, minoff_nxt;
    logic pc_nxt, comm_watchdog_timeout_flag_nxt, stand_nxt;
    logic [CH-1:0] sw_nxt, ls_on_nxt, dis_nxt;
    logic [TIMER_WIDTH-1:0] timer_r [CH];
    logic [TIMER_WIDTH-1:0] timer_nxt [CH];
    logic [CH-1:0] trip, busy, latch_trip, latched;
    logic auto_restart, timer_std;

    // Comparators are asynchronous to the system clock
    ldmc_sync #(.WIDTH(3 + 7 * CH)) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({analog_supply_ok_i, digital_supply_ok_i, limp_home_current_low_i, dimming_input_i,
                  short_detect_i, bootstrap_uv_i, high_side_limit_i, low_side_limit_i,
                  error_amp_ov_i, min_off_time_i}),
        .sync_o({supply_a_s, supply_d_s, lhi_low_s, dim_s, short_s, bst_s, hs_s, ls_s, eaov_s, minoff_s})
    );

    // Watchdog idles in standalone, sleep and limp-home
    assign wd_run = (state_r == ldmc_pkg::ST_DETECT) ||
                    (wd_en_r && (state_r == ldmc_pkg::ST_LOAD || state_r == ldmc_pkg::ST_RUN));
    ldmc_wdog u_wdog (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(wd_run),
        .restart_i(frame_valid_i),
        .tap_i(watchdog_tap_i),
        .timeout_o(wd_timeout)
    );

    assign supplies_ok = supply_a_s && supply_d_s;
    assign auto_restart = (state_r == ldmc_pkg::ST_STANDALONE) || (state_r == ldmc_pkg::ST_LIMP);
    assign timer_std = (state_r == ldmc_pkg::ST_STANDALONE);
    assign trip = hs_s | ls_s;
    assign latch_trip = auto_restart ? ldmc_pkg::CHAN_OFF : (latch_cfg_i & trip);
    // Latched fault holds until its flag is read away
    assign latched = auto_restart ? ldmc_pkg::CHAN_OFF :
                     (latch_cfg_i & (high_side_limit_flag_o | low_side_limit_flag_o));

    // Set wins over a clear; a live condition also keeps the flag
    function automatic logic [CH-1:0] sticky(input logic [CH-1:0] flag, input logic [CH-1:0] cond,
                                             input logic clr);
        return cond | (flag & {CH{~clr}});
    endfunction : sticky

    // Mode and control bits
    always_comb begin
        state_nxt = state_r;
        chan_en_nxt = chan_en_r;
        limp_sw_nxt = limp_sw_r;
        wd_en_nxt = wd_en_r;
        wd_cnt_nxt = wd_cnt_r;
        if (wd_timeout && state_r == ldmc_pkg::ST_RUN) begin
            wd_cnt_nxt = wd_cnt_r + 2'h1;
        end
        if (frame_valid_i || state_r != ldmc_pkg::ST_RUN) begin
            wd_cnt_nxt = 2'h0;
        end
        if (sys_cfg_a_write_i && state_r != ldmc_pkg::ST_SLEEP) begin
            chan_en_nxt = cfg_channel_enable_i;
            limp_sw_nxt = cfg_limp_home_switch_i;
            wd_en_nxt = cfg_watchdog_enable_i;
        end
        chan_en_nxt = chan_en_nxt & ~latch_trip;
        case (state_r)
            ldmc_pkg::ST_POR: begin
                state_nxt = ldmc_pkg::ST_DETECT;
            end
            ldmc_pkg::ST_DETECT: begin
                chan_en_nxt = ldmc_pkg::CHAN_OFF;
                if (wd_timeout) begin
                    state_nxt = ldmc_pkg::ST_STANDALONE;
                end else if (frame_valid_i) begin
                    state_nxt = ldmc_pkg::ST_LOAD;
                end
            end
            ldmc_pkg::ST_STANDALONE: begin
                chan_en_nxt = chan_en_r;
                limp_sw_nxt = limp_sw_r;
                wd_en_nxt = wd_en_r;
                if (reset_write_i && reset_code_i == ldmc_pkg::RESET_TO_LOAD) begin
                    state_nxt = ldmc_pkg::ST_LOAD;
                end else if (reset_write_i && reset_code_i == ldmc_pkg::RESET_TO_DETECT &&
                             !comm_watchdog_timeout_flag_o) begin
                    state_nxt = ldmc_pkg::ST_DETECT;
                end
                if (state_nxt != ldmc_pkg::ST_STANDALONE) begin
                    chan_en_nxt = ldmc_pkg::CHAN_OFF;
                    limp_sw_nxt = ldmc_pkg::LIMP_SW_DEFAULT;
                    wd_en_nxt = ldmc_pkg::WDOG_EN_DEFAULT;
                end
            end
            ldmc_pkg::ST_LOAD: begin
                if (sleep_write_i && sleep_code_i == ldmc_pkg::SLEEP_ENTER) begin
                    state_nxt = ldmc_pkg::ST_SLEEP;
                    chan_en_nxt = ldmc_pkg::CHAN_OFF;
                end else if (chan_en_nxt != ldmc_pkg::CHAN_OFF && !power_cycled_flag_o) begin
                    state_nxt = ldmc_pkg::ST_RUN;
                end else begin
                    chan_en_nxt = ldmc_pkg::CHAN_OFF;
                end
            end
            ldmc_pkg::ST_RUN: begin
                if (sleep_write_i && sleep_code_i == ldmc_pkg::SLEEP_ENTER) begin
                    state_nxt = ldmc_pkg::ST_SLEEP;
                    chan_en_nxt = ldmc_pkg::CHAN_OFF;
                end else if (limp_sw_r || (wd_en_r && wd_cnt_nxt == ldmc_pkg::WDOG_LIMP_COUNT)) begin
                    state_nxt = ldmc_pkg::ST_LIMP;
                end else if (chan_en_nxt == ldmc_pkg::CHAN_OFF) begin
                    state_nxt = ldmc_pkg::ST_LOAD;
                end
            end
            ldmc_pkg::ST_SLEEP: begin
                chan_en_nxt = ldmc_pkg::CHAN_OFF;
                if (sleep_write_i && sleep_code_i == ldmc_pkg::SLEEP_WAKE) begin
                    state_nxt = ldmc_pkg::ST_LOAD;
                end
            end
            ldmc_pkg::ST_LIMP: begin
                if (!limp_sw_r && !comm_watchdog_timeout_flag_o) begin
                    state_nxt = ldmc_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = ldmc_pkg::ST_POR;
            end
        endcase
        if (!supplies_ok) begin
            state_nxt = ldmc_pkg::ST_POR;
            chan_en_nxt = ldmc_pkg::CHAN_OFF;
            limp_sw_nxt = ldmc_pkg::LIMP_SW_DEFAULT;
            wd_en_nxt = ldmc_pkg::WDOG_EN_DEFAULT;
            wd_cnt_nxt = 2'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= ldmc_pkg::ST_POR;
            chan_en_r <= ldmc_pkg::CHAN_OFF;
            limp_sw_r <= ldmc_pkg::LIMP_SW_DEFAULT;
            wd_en_r <= ldmc_pkg::WDOG_EN_DEFAULT;
            wd_cnt_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            chan_en_r <= chan_en_nxt;
            limp_sw_r <= limp_sw_nxt;
            wd_en_r <= wd_en_nxt;
            wd_cnt_r <= wd_cnt_nxt;
        end
    end

    // Status flags, fault timers and drive outputs
    always_comb begin
        short_nxt = sticky(chan_short_flag_o, short_s, status_a_read_done_i);
        hs_f_nxt = sticky(high_side_limit_flag_o, hs_s, status_a_read_done_i);
        ls_f_nxt = sticky(low_side_limit_flag_o, ls_s, status_a_read_done_i);
        eaov_nxt = sticky(error_amp_overvoltage_flag_o, eaov_s, status_a_read_done_i);
        bst_f_nxt = sticky(bootstrap_undervoltage_flag_o, bst_s, status_b_read_done_i);
        minoff_nxt = sticky(min_off_time_flag_o, minoff_s, status_b_read_done_i);
        pc_nxt = power_cycled_flag_o & ~status_c_read_done_i;
        comm_watchdog_timeout_flag_nxt = wd_timeout | (comm_watchdog_timeout_flag_o & ~status_c_read_done_i);
        for (int c = 0; c < CH; c++) begin
            // Standalone always uses the shortest restart time
            if (trip[c]) begin
                timer_nxt[c] = TIMER_WIDTH'(FAULT_CYCLES) << (timer_std ? 2'h0 : fault_timer_sel_i);
            end else if (timer_r[c] != '0) begin
                timer_nxt[c] = timer_r[c] - {{(TIMER_WIDTH-1){1'b0}}, 1'b1};
            end else begin
                timer_nxt[c] = '0;
            end
            busy[c] = trip[c] || (timer_r[c] != '0);
        end
        // Short flag deliberately absent from every enable term
        case (state_r)
            ldmc_pkg::ST_RUN: sw_nxt = chan_en_r & ~latched & ~busy & ~bst_s & {CH{~limp_sw_r}};
            ldmc_pkg::ST_STANDALONE: sw_nxt = dim_s & ~busy & ~bst_s & {CH{~lhi_low_s}};
            ldmc_pkg::ST_LIMP: sw_nxt = ~busy & ~bst_s & {CH{~lhi_low_s}};
            default: sw_nxt = ldmc_pkg::CHAN_OFF;
        endcase
        ls_on_nxt = (state_r == ldmc_pkg::ST_RUN || auto_restart) ? hs_s : ldmc_pkg::CHAN_OFF;
        dis_nxt = trip | latched;
        stand_nxt = timer_std;
        if (!supplies_ok) begin
            short_nxt = ldmc_pkg::CHAN_OFF;
            hs_f_nxt = ldmc_pkg::CHAN_OFF;
            ls_f_nxt = ldmc_pkg::CHAN_OFF;
            eaov_nxt = ldmc_pkg::CHAN_OFF;
            bst_f_nxt = ldmc_pkg::CHAN_OFF;
            minoff_nxt = ldmc_pkg::CHAN_OFF;
            pc_nxt = ldmc_pkg::PWR_CYCLED_DEFAULT;
            comm_watchdog_timeout_flag_nxt = 1'b0;
            sw_nxt = ldmc_pkg::CHAN_OFF;
            ls_on_nxt = ldmc_pkg::CHAN_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            chan_short_flag_o <= ldmc_pkg::CHAN_OFF;
            high_side_limit_flag_o <= ldmc_pkg::CHAN_OFF;
            low_side_limit_flag_o <= ldmc_pkg::CHAN_OFF;
            error_amp_overvoltage_flag_o <= ldmc_pkg::CHAN_OFF;
            bootstrap_undervoltage_flag_o <= ldmc_pkg::CHAN_OFF;
            min_off_time_flag_o <= ldmc_pkg::CHAN_OFF;
            power_cycled_flag_o <= ldmc_pkg::PWR_CYCLED_DEFAULT;
            comm_watchdog_timeout_flag_o <= 1'b0;
            switch_enable_o <= ldmc_pkg::CHAN_OFF;
            low_side_on_o <= ldmc_pkg::CHAN_OFF;
            comp_discharge_o <= ldmc_pkg::CHAN_OFF;
            standalone_defaults_o <= 1'b0;
            for (int c = 0; c < CH; c++) begin
                timer_r[c] <= '0;
            end
        end else begin
            chan_short_flag_o <= short_nxt;
            high_side_limit_flag_o <= hs_f_nxt;
            low_side_limit_flag_o <= ls_f_nxt;
            error_amp_overvoltage_flag_o <= eaov_nxt;
            bootstrap_undervoltage_flag_o <= bst_f_nxt;
            min_off_time_flag_o <= minoff_nxt;
            power_cycled_flag_o <= pc_nxt;
            comm_watchdog_timeout_flag_o <= comm_watchdog_timeout_flag_nxt;
            switch_enable_o <= sw_nxt;
            low_side_on_o <= ls_on_nxt;
            comp_discharge_o <= dis_nxt;
            standalone_defaults_o <= stand_nxt;
            for (int c = 0; c < CH; c++) begin
                timer_r[c] <= timer_nxt[c];
            end
        end
    end

    assign mode_o = state_r;
    assign channel_enable_bit_o = chan_en_r;
    assign limp_home_switch_bit_o = limp_sw_r;
    assign comm_watchdog_enable_bit_o = wd_en_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_short_flag_set: assert property (short_s[0] && supplies_ok |=> chan_short_flag_o[0])
        else $error("short flag not set");
    a_short_keeps_run: assert property (state_r == ldmc_pkg::ST_RUN && $rose(short_s[0]) && supplies_ok
        && !sleep_write_i && !limp_sw_r && !sys_cfg_a_write_i && !trip[0] && !wd_timeout
        |=> state_r == ldmc_pkg::ST_RUN)
        else $error("short left run mode");
    a_boot_uv_block: assert property (bst_s[1] && supplies_ok |=> bootstrap_undervoltage_flag_o[1]
        && !switch_enable_o[1])
        else $error("bootstrap undervoltage not handled");
    a_supply_low_off: assert property (!supplies_ok |=> state_r == ldmc_pkg::ST_POR
        && chan_en_r == ldmc_pkg::CHAN_OFF ##1 switch_enable_o == ldmc_pkg::CHAN_OFF)
        else $error("supply low did not hold defaults");
    a_detect_timeout: assert property (state_r == ldmc_pkg::ST_DETECT && wd_timeout && supplies_ok
        |=> state_r == ldmc_pkg::ST_STANDALONE)
        else $error("watchdog expiry missed standalone");
    a_detect_frame: assert property (state_r == ldmc_pkg::ST_DETECT && frame_valid_i && !wd_timeout
        && supplies_ok |=> state_r == ldmc_pkg::ST_LOAD)
        else $error("valid frame missed load");
    a_load_enable_low: assert property (state_r == ldmc_pkg::ST_LOAD |-> chan_en_r == ldmc_pkg::CHAN_OFF
        ##1 switch_enable_o == ldmc_pkg::CHAN_OFF)
        else $error("enable high in load");
    a_sleep_entry: assert property ((state_r == ldmc_pkg::ST_LOAD || state_r == ldmc_pkg::ST_RUN)
        && sleep_write_i && sleep_code_i == ldmc_pkg::SLEEP_ENTER && supplies_ok
        |=> state_r == ldmc_pkg::ST_SLEEP ##2 switch_enable_o == ldmc_pkg::CHAN_OFF)
        else $error("sleep entry failed");
    a_limp_entry: assert property (state_r == ldmc_pkg::ST_RUN && limp_sw_r && supplies_ok && !sleep_write_i
        |=> state_r == ldmc_pkg::ST_LIMP)
        else $error("limp switch ignored");
    a_hs_low_side: assert property (state_r == ldmc_pkg::ST_RUN && hs_s[0] && supplies_ok
        |=> low_side_on_o[0] && comp_discharge_o[0] && !switch_enable_o[0])
        else $error("high-side limit response wrong");

    c_standalone: cover property (state_r == ldmc_pkg::ST_DETECT ##1 state_r == ldmc_pkg::ST_STANDALONE);
    c_run: cover property (state_r == ldmc_pkg::ST_LOAD ##1 state_r == ldmc_pkg::ST_RUN);
    c_limp: cover property (state_r == ldmc_pkg::ST_RUN ##1 state_r == ldmc_pkg::ST_LIMP);
    c_wake: cover property (state_r == ldmc_pkg::ST_SLEEP ##1 state_r == ldmc_pkg::ST_LOAD);
endmodule : ldmc_core
`default_nettype wire

// file: test/ldmc_host_model.sv
// Host model: register strobes that the SPI logic presents to the core
`default_nettype none
module ldmc_host_model (
    input wire logic clk_i,
    output logic [6:0] stb_o,
    output logic [7:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        stb_o = 7'h00;
        dat_o = 8'h00;
    end
    // One-cycle strobe; data inverts afterwards so stale values are never trusted
    task automatic op(input int s, input logic [7:0] d);
        @(negedge clk_i);
        stb_o[s] = 1'h1;
        dat_o = d;
        @(negedge clk_i);
        stb_o = 7'h00;
        dat_o = ~d;
    endtask : op
endmodule : ldmc_host_model
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the mode controller
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t: %h vs %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic sup = 1'h1;
    logic [1:0] sc = 2'h0, hs = 2'h0, e, en, lso, shf, hsf, eaf, bsf, mof, swe, lat = 2'h0, lsf, cd;
    logic [5:0] diag = 6'h00;
    logic [6:0] stb, mode;
    logic [7:0] dat, rnd = 8'h30;
    logic pc, sa, lsw, wde, wto, lhl = 1'h0;
    int num_errors = 0, compares = 0;
    always #2 clk_i = ~clk_i;
    ldmc_host_model u_ldmc_host_model (.clk_i(clk_i), .stb_o(stb), .dat_o(dat));
    // Short restart timer and tap 3 keep the run brief
    ldmc_core #(.FAULT_CYCLES(8)) u_ldmc_core (.clk_i(clk_i), .reset_i(reset_i), .analog_supply_ok_i(sup),
        .digital_supply_ok_i(sup), .limp_home_current_low_i(lhl), .dimming_input_i(2'h3), .short_detect_i(sc),
        .bootstrap_uv_i(diag[1:0]), .high_side_limit_i(hs), .low_side_limit_i(hs), .error_amp_ov_i(diag[5:4]),
        .min_off_time_i(diag[3:2]), .frame_valid_i(stb[0]), .sys_cfg_a_write_i(stb[1]),
        .cfg_channel_enable_i(dat[1:0]), .cfg_limp_home_switch_i(dat[2]), .cfg_watchdog_enable_i(dat[3]),
        .latch_cfg_i(lat), .fault_timer_sel_i(2'h0), .watchdog_tap_i(5'h03), .reset_write_i(stb[2]),
        .reset_code_i(dat), .sleep_write_i(stb[3]), .sleep_code_i(dat[1:0]), .status_a_read_done_i(stb[4]),
        .status_b_read_done_i(stb[5]), .status_c_read_done_i(stb[6]), .mode_o(mode), .channel_enable_bit_o(en),
        .limp_home_switch_bit_o(lsw), .comm_watchdog_enable_bit_o(wde), .switch_enable_o(swe), .low_side_on_o(lso),
        .comp_discharge_o(cd), .standalone_defaults_o(sa), .chan_short_flag_o(shf), .high_side_limit_flag_o(hsf),
        .low_side_limit_flag_o(lsf), .error_amp_overvoltage_flag_o(eaf), .bootstrap_undervoltage_flag_o(bsf),
        .min_off_time_flag_o(mof), .power_cycled_flag_o(pc), .comm_watchdog_timeout_flag_o(wto));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // Enable pattern never zero, else the write would not leave load
    function automatic logic [1:0] en_of(input logic [7:0] r);
        return (r[1:0] == 2'h0) ? 2'h1 : r[1:0];
    endfunction : en_of
    task automatic summarize();
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic wait_mode(input logic [6:0] m);
        for (int i = 0; i < 99 && mode !== m; i++) @(negedge clk_i);
        `CHK(mode, m)
        if (mode !== m) summarize();
    endtask : wait_mode
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask : step
    initial begin
        step(16);
        `CHK({mode, pc, en}, {7'h01, 1'h1, 2'h0})
        reset_i = 1'h0;
        wait_mode(ldmc_pkg::ST_DETECT);
        wait_mode(ldmc_pkg::ST_STANDALONE);
        // Defaults flag and drive follow the mode by one register stage
        step(1);
        `CHK({sa, swe}, 3'h7)
        `CHK(wto, 1'h1)
        lhl = 1'h1;
        step(4);
        `CHK(swe, 2'h0)
        lhl = 1'h0;
        u_ldmc_host_model.op(2, ldmc_pkg::RESET_TO_DETECT);
        step(2);
        `CHK(mode, ldmc_pkg::ST_STANDALONE)
        u_ldmc_host_model.op(6, 8'h00);
        u_ldmc_host_model.op(2, ldmc_pkg::RESET_TO_DETECT);
        wait_mode(ldmc_pkg::ST_DETECT);
        wait_mode(ldmc_pkg::ST_STANDALONE);
        u_ldmc_host_model.op(2, ldmc_pkg::RESET_TO_LOAD);
        wait_mode(ldmc_pkg::ST_LOAD);
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            e = en_of(rnd);
            u_ldmc_host_model.op(1, {6'h00, e});
            wait_mode(ldmc_pkg::ST_RUN);
            `CHK(en, e)
            sc = e;
            // Short leads the limits by a cycle so it rises alone in run
            step(1);
            // Bootstrap low on each enabled channel gives the third open-load pattern
            diag = {rnd[7:4], e};
            hs = e;
            step(4);
            `CHK(shf, e)
            `CHK({eaf, mof, bsf}, diag)
            `CHK({lso, hsf, lsf}, {e, e, e})
            sc = 2'h0;
            diag = 6'h00;
            hs = 2'h0;
            step(12);
            `CHK(swe, e)
            u_ldmc_host_model.op(4, 8'h00);
            u_ldmc_host_model.op(5, 8'h00);
            `CHK({shf, hsf, lsf, eaf, bsf, mof}, 12'h000)
        end
        u_ldmc_host_model.op(3, {6'h00, ldmc_pkg::SLEEP_ENTER});
        wait_mode(ldmc_pkg::ST_SLEEP);
        `CHK(en, 2'h0)
        u_ldmc_host_model.op(3, {6'h00, ldmc_pkg::SLEEP_WAKE});
        wait_mode(ldmc_pkg::ST_LOAD);
        u_ldmc_host_model.op(1, 8'h01);
        wait_mode(ldmc_pkg::ST_RUN);
        lat = 2'h1;
        hs = 2'h1;
        wait_mode(ldmc_pkg::ST_LOAD);
        `CHK({en, cd}, {2'h0, 2'h1})
        hs = 2'h0;
        lat = 2'h0;
        u_ldmc_host_model.op(1, 8'h01);
        wait_mode(ldmc_pkg::ST_RUN);
        u_ldmc_host_model.op(1, 8'h05);
        wait_mode(ldmc_pkg::ST_LIMP);
        `CHK({lsw, wde}, 2'h2)
        // Watchdog on and no frames: three timeouts in run bring limp-home back
        u_ldmc_host_model.op(1, 8'h09);
        u_ldmc_host_model.op(6, 8'h00);
        wait_mode(ldmc_pkg::ST_RUN);
        wait_mode(ldmc_pkg::ST_LIMP);
        sup = 1'h0;
        wait_mode(ldmc_pkg::ST_POR);
        `CHK({en, pc, lsw, wde}, {2'h0, 1'h1, 1'h0, 1'h1})
        sup = 1'h1;
        wait_mode(ldmc_pkg::ST_DETECT);
        u_ldmc_host_model.op(0, 8'h00);
        wait_mode(ldmc_pkg::ST_LOAD);
        u_ldmc_host_model.op(1, 8'h01);
        step(2);
        `CHK({mode, en}, {ldmc_pkg::ST_LOAD, 2'h0})
        summarize();
    end
endmodule : tb
`default_nettype wire
